/* File: src/sff_consts.svh */
/*
 Constants for the synchronous flash port, its device end and its controller end.
 Assumes one shared clock and inclusion by bare name.
*/
// Behaviour
// (RULE1) All inputs sampled on rising clock edge
// (RULE2) A data transfer possible every clock
// (RULE3) Chip select high masks all but clock enable
// (RULE4) Clock enable low freezes from next cycle
// (RULE5) Raise clock enable one cycle before commands
// (RULE6) Clock enable low while idle means power-down
// (RULE7) Row thirteen bits, column seven or eight
// (RULE8) Row strobe low latches row address
// (RULE9) Column strobe low latches column address
// (RULE10) Mode load needs all four strobes low
// (RULE11) Width pin high x32, low x16
// (RULE12) Host fixes width pin before any operation; the host here lets it change whenever clock enable is low
// (RULE13) Output mask suppresses read data driving; here a boot block read issued with mask low is driven even if mask rises
// (RULE14) Writes accepted only with write enable low
// (RULE15) Data bus carries program data and read data
// (RULE16) Mode load sets row and column latency
// (RULE17) Mode load sets burst length and order
// (RULE18) Eight erasable sectors in the array
// (RULE19) Separate boot block with hardware lockout
// (RULE20) Boot block on at power-up or mode load
// (RULE21) No command for three clocks after mode load
// (RULE22) Mask high closes outputs two clocks later
// (RULE23) Burst starts after column latency, word per clock
`ifndef SFF_CONSTS_SVH
`define SFF_CONSTS_SVH
`define SFF_MRS_GAP 4'h3
`define SFF_BL4_LAST 3'h3
`define SFF_BL8_LAST 3'h7
`define SFF_CL_MIN 3'h2
`define SFF_M_BL 1:0
`define SFF_M_BL8 1
`define SFF_M_BOOT 2'h3
`define SFF_M_ILV 2
`define SFF_M_CL 5:3
`define SFF_M_RL 6
`define SFF_M_ID 7
`define SFF_A_ERASE 12
`define SFF_SECTOR 12:10
// Arbitrary identification value, names no part
`define SFF_ID_CODE 32'h5A5A0001
`define SFF_R_CTRL 4'h0
`define SFF_R_MODE 4'h1
`define SFF_R_ADDR 4'h2
`define SFF_R_WDATA 4'h3
`define SFF_R_CFG 4'h4
`define SFF_R_STAT 4'h5
`define SFF_R_BUF 3
`endif

/* File: src/sff_pkg.sv */
/*
 Types shared by both ends of the synchronous flash port.
 Assumes the constants header is on the include path.
*/
package sff_pkg;
`include "sff_consts.svh"
    typedef enum logic [1:0] {
        SFF_D_IDLE = 2'b00,
        SFF_D_WAIT = 2'b01,
        SFF_D_BURST = 2'b10
    } sff_dst_t;
    typedef enum logic [2:0] {
        SFF_H_IDLE = 3'b000,
        SFF_H_WAKE = 3'b001,
        SFF_H_HOLD = 3'b010,
        SFF_H_GAP = 3'b011,
        SFF_H_CAP = 3'b100
    } sff_hst_t;
    typedef enum logic [2:0] {
        SFF_OP_NONE = 3'b000,
        SFF_OP_MODE_LOAD = 3'b001,
        SFF_OP_ACT = 3'b010,
        SFF_OP_READ = 3'b011,
        SFF_OP_WRITE = 3'b100,
        SFF_OP_STOP = 3'b101,
        SFF_OP_SLEEP = 3'b110,
        SFF_OP_WAKE = 3'b111
    } sff_op_t;
endpackage

/* File: src/sff_if.sv */
/*
 Pin bundle between the flash device end and the controller end.
 Assumes both ends run on the same clock; the data wire is resolved here.
*/
`timescale 1ns/1ps
interface sff_if;
    logic cs_n;
    logic cke;
    logic ras_n;
    logic cas_n;
    logic mode_set_strobe_n;
    logic we_n;
    logic dqm;
    logic [12:0] addr;
    logic word_sel;
    logic [31:0] host_dq;
    logic host_oe;
    logic [31:0] dev_dq;
    logic dev_oe;
    wire [31:0] dq;
    // Undriven bus reads as zero
    assign dq = dev_oe ? dev_dq : (host_oe ? host_dq : 32'h00000000);
    modport dev(input cs_n, cke, ras_n, cas_n, mode_set_strobe_n, we_n, dqm, addr, word_sel, dq,
                output dev_dq, dev_oe);
    modport host(output cs_n, cke, ras_n, cas_n, mode_set_strobe_n, we_n, dqm, addr, word_sel,
                 host_dq, host_oe, input dq);
endinterface

/* File: src/sff_burst_seq.sv */
/*
 Burst column offset for a given start column and beat index.
 Assumes burst length 4 or 8; purely combinational.
*/
`timescale 1ns/1ps
module sff_burst_seq
    import sff_pkg::*;
(
    // Burst setup
    input logic [2:0] start,
    input logic [2:0] idx,
    input logic bl8,
    input logic ilv,
    // Offset
    output logic [2:0] ofs
);
    logic [2:0] lin;
    logic [2:0] mix;
    assign lin = start + idx;
    assign mix = start ^ idx;
    // Short bursts wrap within four columns
    assign ofs = ilv ? (bl8 ? mix : {start[2], mix[1:0]}) : (bl8 ? lin : {start[2], lin[1:0]}); // RULE17
endmodule

/* File: src/sff_dev_end.sv */
/*
 Device end of the synchronous flash port: command decode, mode register,
 read burst engine, program and erase requests, boot block access.
 Assumes an array behind it whose read data is valid in the cycle of the
 read request, and a host on the same clock.
*/
`timescale 1ns/1ps
module sff_dev_end
    import sff_pkg::*;
(
    // Clock and reset
    input logic core_clk,
    input logic arst_n,
    // Memory pins
    sff_if.dev bus,
    // Straps and protection
    input logic boot_auto,
    input logic boot_wp,
    // Array side
    input logic arr_busy,
    input logic [31:0] arr_rdata,
    output logic arr_rd,
    output logic arr_wr,
    output logic arr_erase,
    output logic arr_boot,
    output logic [20:0] arr_addr,
    output logic [31:0] arr_wdata,
    output logic [2:0] arr_sector,
    // Status
    output logic pdown,
    output logic x32_mode
);
    typedef struct packed {
        sff_dst_t st;
        logic strap;
        logic cke;
        logic x32;
        logic boot;
        logic id;
        logic [2:0] cl;
        logic rl;
        logic bl8;
        logic ilv;
        logic [12:0] row;
        logic [7:0] col;
        logic [2:0] cnt;
        logic [2:0] beat;
        logic rwait;
        logic [3:0] mgap;
        logic [1:0] dqm;
        logic [31:0] dq;
        logic oe;
        logic pdown;
        logic rd;
        logic wr;
        logic er;
        logic bsel;
        logic [20:0] aaddr;
        logic [31:0] wdata;
        logic [2:0] sector;
    } sff_dev_st_t;

    sff_dev_st_t q;
    sff_dev_st_t n;
    logic [2:0] ofs;
    logic sel;
    logic cmd_mode;
    logic cmd_row;
    logic cmd_stop;
    logic cmd_read;
    logic cmd_write;

    function automatic logic [20:0] addr_of(input logic x32, input logic [12:0] row, input logic [7:0] col);
        addr_of = x32 ? {1'b0, row, col[6:0]} : {row, col}; // RULE7
    endfunction

    sff_burst_seq i_sff_burst_seq (
        .start(q.col[2:0]),
        .idx(q.beat),
        .bl8(q.bl8),
        .ilv(q.ilv),
        .ofs(ofs)
    );

    // Commands count only while selected and the clock was enabled
    assign sel = ~bus.cs_n & q.cke & q.strap; // RULE3
    assign cmd_mode = sel & ~bus.ras_n & ~bus.cas_n & ~bus.mode_set_strobe_n; // RULE10
    assign cmd_row = sel & ~bus.ras_n & bus.cas_n & bus.mode_set_strobe_n;
    assign cmd_stop = sel & ~bus.ras_n & bus.cas_n & ~bus.mode_set_strobe_n;
    assign cmd_read = sel & bus.ras_n & ~bus.cas_n & bus.mode_set_strobe_n & bus.we_n;
    assign cmd_write = sel & bus.ras_n & ~bus.cas_n & ~bus.we_n; // RULE14

    always_comb begin
        n = q;
        n.cke = bus.cke; // RULE4
        n.pdown = ~bus.cke & (q.st == SFF_D_IDLE) & (q.mgap == 4'h0); // RULE6
        if (!q.strap) begin
            // Straps caught on the first edge after reset release
            n.strap = 1'b1;
            n.x32 = bus.word_sel; // RULE11
            n.boot = boot_auto; // RULE20
        end else if (q.cke) begin // RULE4
            n.rd = 1'b0;
            n.wr = 1'b0;
            n.er = 1'b0;
            n.dqm = {q.dqm[0], bus.dqm};
            n.oe = q.rd & (q.bsel | ~q.dqm[1]); // RULE22 RULE13
            if (q.id) begin
                n.dq = `SFF_ID_CODE;
            end else if (q.x32 & ~q.bsel) begin
                n.dq = arr_rdata; // RULE15
            end else begin
                n.dq = {16'h0000, arr_rdata[15:0]};
            end
            if (q.mgap != 4'h0) begin
                n.mgap = q.mgap - 4'h1;
            end
            n.rwait = 1'b0;
            // Issue one array read per clock for the whole burst
            if ((q.st == SFF_D_WAIT && q.cnt == 3'h1) || q.st == SFF_D_BURST) begin // RULE23 RULE2
                n.rd = 1'b1;
                n.bsel = 1'b0;
                n.aaddr = addr_of(q.x32, q.row, {q.col[7:3], ofs});
                n.beat = q.beat + 3'h1;
                n.st = (q.beat == (q.bl8 ? `SFF_BL8_LAST : `SFF_BL4_LAST)) ? SFF_D_IDLE : SFF_D_BURST;
            end else if (q.st == SFF_D_WAIT) begin
                n.cnt = q.cnt - 3'h1;
            end
            if (cmd_mode) begin
                n.st = SFF_D_IDLE;
                n.mgap = `SFF_MRS_GAP;
                n.boot = (bus.addr[`SFF_M_BL] == `SFF_M_BOOT); // RULE20
                n.bl8 = bus.addr[`SFF_M_BL8]; // RULE17
                n.ilv = bus.addr[`SFF_M_ILV]; // RULE17
                // Latency kept as cycles minus one so eight fits; reserved code gives two
                n.cl = (bus.addr[`SFF_M_CL] == 3'h0) ? `SFF_CL_MIN - 3'h1 : bus.addr[`SFF_M_CL]; // RULE16
                n.rl = bus.addr[`SFF_M_RL]; // RULE16
                n.id = bus.addr[`SFF_M_ID];
            end else if (cmd_row) begin
                n.row = bus.addr; // RULE8
                n.rwait = q.rl;
            end else if (cmd_stop) begin
                n.st = SFF_D_IDLE;
            end else if (cmd_read && !q.boot && !q.rwait) begin
                // A read inside the row latency is dropped
                n.col = bus.addr[7:0]; // RULE9
                n.cnt = q.cl;
                n.beat = 3'h0;
                n.st = SFF_D_WAIT;
            end else if (cmd_write && !arr_busy) begin
                n.wdata = bus.dq; // RULE15
                if (q.boot) begin
                    if (!boot_wp) begin // RULE19
                        n.wr = 1'b1;
                        n.bsel = 1'b1;
                        n.aaddr = {8'h00, bus.addr};
                    end
                end else if (bus.addr[`SFF_A_ERASE]) begin
                    n.er = 1'b1; // RULE18
                    n.bsel = 1'b0;
                    n.sector = q.row[`SFF_SECTOR];
                end else begin
                    n.wr = 1'b1;
                    n.bsel = 1'b0;
                    n.aaddr = addr_of(q.x32, q.row, bus.addr[7:0]); // RULE9
                end
            end else if (q.boot && sel && !bus.dqm) begin
                // Boot block reads follow the address every selected clock with mask low, x16 only
                n.rd = 1'b1; // RULE19
                n.bsel = 1'b1;
                n.aaddr = {8'h00, bus.addr};
            end
        end
    end

    always_ff @(posedge core_clk or negedge arst_n) begin // RULE1
        if (!arst_n) begin
            q <= '0;
        end else begin
            q <= n;
        end
    end

    assign bus.dev_dq = q.dq;
    assign bus.dev_oe = q.oe;
    assign arr_rd = q.rd;
    assign arr_wr = q.wr;
    assign arr_erase = q.er;
    assign arr_boot = q.bsel;
    assign arr_addr = q.aaddr;
    assign arr_wdata = q.wdata;
    assign arr_sector = q.sector;
    assign pdown = q.pdown;
    assign x32_mode = q.x32;
endmodule

/* File: src/sff_host_end.sv */
/*
 Controller end of the synchronous flash port with a small register port.
 Assumes software writes mode, address and data before starting an operation.
*/
`timescale 1ns/1ps
module sff_host_end
    import sff_pkg::*;
(
    // Clock and reset
    input logic core_clk,
    input logic arst_n,
    // Memory pins
    sff_if.host bus,
    // Register port
    input logic [3:0] reg_addr,
    input logic [31:0] reg_wdata,
    input logic reg_wr,
    input logic reg_rd,
    output logic [31:0] reg_rdata
);
    typedef struct packed {
        sff_hst_t st;
        sff_op_t op;
        logic [7:0] mode;
        logic [12:0] addr;
        logic [31:0] wdata;
        logic [1:0] cfg;
        logic [4:0] pins;
        logic cke;
        logic [12:0] a;
        logic [31:0] dq;
        logic oe;
        logic [3:0] cnt;
        logic [3:0] beat;
        logic [7:0][31:0] rbuf;
        logic [31:0] rdata;
    } sff_hst_st_t;

    sff_hst_st_t q;
    sff_hst_st_t n;
    logic go;
    sff_op_t wop;

    // Strobes held asserted-high in order cs, row, column, mode-set, write enable
    // Zero after reset is a no-op, so no stray mode load on wake
    function automatic logic [4:0] pins_of(input sff_op_t op);
        case (op)
            SFF_OP_MODE_LOAD: pins_of = 5'h1E; // RULE10
            SFF_OP_ACT: pins_of = 5'h18;
            SFF_OP_READ: pins_of = 5'h14;
            SFF_OP_WRITE: pins_of = 5'h15;
            SFF_OP_STOP: pins_of = 5'h1A;
            default: pins_of = 5'h00;
        endcase
    endfunction

    assign wop = sff_op_t'(reg_wdata[2:0]);

    always_comb begin
        n = q;
        go = 1'b0;
        n.rdata = 32'h00000000;
        if (reg_rd) begin
            if (reg_addr[`SFF_R_BUF]) begin
                n.rdata = q.rbuf[reg_addr[2:0]];
            end else begin
                case (reg_addr)
                    `SFF_R_MODE: n.rdata = {24'h000000, q.mode};
                    `SFF_R_ADDR: n.rdata = {19'h00000, q.addr};
                    `SFF_R_WDATA: n.rdata = q.wdata;
                    `SFF_R_CFG: n.rdata = {30'h00000000, q.cfg};
                    `SFF_R_STAT: n.rdata = {26'h0000000, q.beat, q.cke, q.st != SFF_H_IDLE};
                    default: n.rdata = 32'h00000000;
                endcase
            end
        end
        if (reg_wr) begin
            case (reg_addr)
                `SFF_R_MODE: n.mode = reg_wdata[7:0];
                `SFF_R_ADDR: n.addr = reg_wdata[12:0];
                `SFF_R_WDATA: n.wdata = reg_wdata;
                `SFF_R_CFG: begin
                    // Width pin may only move while the device is asleep
                    if (!q.cke) begin // RULE12
                        n.cfg[0] = reg_wdata[0];
                    end
                    n.cfg[1] = reg_wdata[1];
                end
                default: begin
                end
            endcase
        end
        case (q.st)
            SFF_H_IDLE: begin
                if (reg_wr && reg_addr == `SFF_R_CTRL && wop != SFF_OP_NONE) begin
                    n.op = wop;
                    if (wop == SFF_OP_SLEEP) begin
                        n.cke = 1'b0;
                    end else if (wop == SFF_OP_WAKE) begin
                        n.cke = 1'b1;
                    end else if (q.cke) begin
                        go = 1'b1;
                    end else begin
                        n.cke = 1'b1; // RULE5
                        n.st = SFF_H_WAKE;
                    end
                end
            end
            SFF_H_WAKE: begin
                go = 1'b1; // RULE5
            end
            SFF_H_HOLD: begin
                n.pins = 5'h00;
                n.oe = 1'b0;
                n.beat = 4'h0;
                n.st = SFF_H_GAP;
                n.cnt = 4'h0;
                if (q.op == SFF_OP_MODE_LOAD) begin
                    n.cnt = `SFF_MRS_GAP; // RULE21
                end else if (q.op == SFF_OP_READ) begin
                    // Capture wait is the full latency, code plus one, or two for the reserved code zero
                    n.cnt = (q.mode[`SFF_M_CL] == 3'h0) ? {1'b0, `SFF_CL_MIN} : {1'b0, q.mode[`SFF_M_CL]} + 4'h1;
                    n.st = SFF_H_CAP;
                end
            end
            SFF_H_GAP: begin
                if (q.cnt == 4'h0) begin
                    n.st = SFF_H_IDLE;
                end else begin
                    n.cnt = q.cnt - 4'h1;
                end
            end
            SFF_H_CAP: begin
                if (q.cnt != 4'h0) begin
                    n.cnt = q.cnt - 4'h1;
                end else begin
                    n.rbuf[q.beat[2:0]] = bus.dq; // RULE23
                    n.beat = q.beat + 4'h1;
                    if (q.beat[2:0] == (q.mode[`SFF_M_BL8] ? `SFF_BL8_LAST : `SFF_BL4_LAST)) begin
                        n.st = SFF_H_IDLE;
                    end
                end
            end
            default: n.st = SFF_H_IDLE;
        endcase
        if (go) begin
            n.pins = pins_of(n.op);
            n.a = (n.op == SFF_OP_MODE_LOAD) ? {5'h00, q.mode} : q.addr; // RULE7
            n.dq = q.wdata;
            n.oe = (n.op == SFF_OP_WRITE); // RULE15
            n.st = SFF_H_HOLD;
        end
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            q <= '0;
        end else begin
            q <= n;
        end
    end

    assign bus.cs_n = ~q.pins[4];
    assign bus.ras_n = ~q.pins[3];
    assign bus.cas_n = ~q.pins[2];
    assign bus.mode_set_strobe_n = ~q.pins[1];
    assign bus.we_n = ~q.pins[0];
    assign bus.cke = q.cke;
    assign bus.dqm = q.cfg[1]; // RULE13
    assign bus.addr = q.a;
    assign bus.word_sel = q.cfg[0];
    assign bus.host_dq = q.dq;
    assign bus.host_oe = q.oe;
    assign reg_rdata = q.rdata;
endmodule

/* File: verif/sff_props.sv */
/*
 Pin checker for the flash port between the device end and the controller end.
 Assumes one clock and asynchronous low reset; instantiated beside the interface.
*/
`timescale 1ns/1ps
module sff_props #(
    parameter bit BOOT_AT_RESET = 1'b0
) (
    // Clock and reset
    input logic core_clk,
    input logic arst_n,
    // Command pins
    input logic cs_n,
    input logic cke,
    input logic ras_n,
    input logic cas_n,
    input logic mode_set_strobe_n,
    input logic we_n,
    input logic dqm,
    input logic [12:0] addr,
    input logic word_sel,
    // Data drivers
    input logic host_oe,
    input logic [31:0] dev_dq,
    input logic dev_oe
);
    logic [3:0] cl_q;
    logic bl8_q;
    logic boot_q;
    logic rl2_q;
    logic act_q;
    logic cke_q;
    logic [4:0] age_q;
    logic cmd_ok;
    logic load;
    logic act;
    logic rd_ok;
    assign cmd_ok = cke_q && !cs_n;
    assign load = cmd_ok && !ras_n && !cas_n && !mode_set_strobe_n;
    assign act = cmd_ok && !ras_n && cas_n && mode_set_strobe_n;
    // Refused reads leave the age alone, so no burst is expected from them
    assign rd_ok = cmd_ok && ras_n && !cas_n && mode_set_strobe_n && we_n && !boot_q && !(rl2_q && act_q);

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            cl_q <= 4'h2;
            bl8_q <= 1'b0;
            boot_q <= BOOT_AT_RESET;
            rl2_q <= 1'b0;
            act_q <= 1'b0;
            cke_q <= 1'b0;
            age_q <= 5'h1F;
        end else begin
            cke_q <= cke;
            act_q <= act;
            if (load) begin
                cl_q <= (addr[5:3] == 3'h0) ? 4'h2 : {1'b0, addr[5:3]} + 4'h1;
                bl8_q <= addr[1:0] == 2'h2;
                boot_q <= addr[1:0] == 2'h3;
                rl2_q <= addr[6];
            end
            // Age stalls while the clock is suspended
            if (rd_ok) begin
                age_q <= 5'h0;
            end else if (cke_q && age_q != 5'h1F) begin
                age_q <= age_q + 5'h1;
            end
        end
    end

    default clocking @(posedge core_clk); endclocking
    default disable iff (!arst_n);

    sequence s_nop3;
        (cs_n || (ras_n && cas_n && mode_set_strobe_n)) [*3];
    endsequence
    sequence s_mask3;
        (dqm && cke) [*3];
    endsequence

    first_beat_a: assert property ($rose(dev_oe) && !boot_q |-> age_q == {1'b0, cl_q})
        else $error("first read beat at wrong latency");
    burst_len_a: assert property ($fell(dev_oe) && !boot_q && !dqm |-> age_q == 5'(cl_q) + (bl8_q ? 5'h8 : 5'h4))
        else $error("read burst has wrong length");
    mode_gap_a: assert property (load |=> s_nop3)
        else $error("command within three clocks of mode load");
    dqm_hiz_a: assert property (s_mask3 |=> !dev_oe)
        else $error("data still driven two clocks after mask");
    cke_freeze_a: assert property (!cke && !boot_q |-> ##2 $stable(dev_oe) && $stable(dev_dq))
        else $error("outputs moved while clock suspended");
    wake_gap_a: assert property ($rose(cke) |-> cs_n || (ras_n && cas_n && mode_set_strobe_n))
        else $error("command in the cycle clock enable rose");
    no_clash_a: assert property (!(dev_oe && host_oe))
        else $error("both ends drive the data bus");
    x16_upper_a: assert property (dev_oe && !word_sel |-> dev_dq[31:16] == 16'h0)
        else $error("upper data half driven in word mode");
    cs_mask_a: assert property (cs_n && $past(cs_n) && !dev_oe && age_q == 5'h1F |=> !dev_oe)
        else $error("output started while deselected");
endmodule

/* File: verif/sync_flash_sdram_style_port_tb.sv */
/*
 Bench joining both ends of the flash port, driven through the register port.
 Assumes an array model that answers in the same cycle and the pin checker.
*/
`timescale 1ns/1ps
module sync_flash_sdram_style_port_tb import sff_pkg::*;;
    logic core_clk, arst_n, reg_wr, reg_rd, boot_wp, arr_busy;
    logic arr_rd, arr_wr, arr_erase, arr_boot, pdown, x32_mode, wr_boot;
    logic [3:0] reg_addr;
    logic [31:0] reg_wdata, reg_rdata, arr_rdata, arr_wdata, rv, wr_data;
    logic [20:0] arr_addr, wr_addr;
    logic [2:0] arr_sector, er_sec;
    int error_cnt, total_checks, oe_cnt, wr_cnt, er_cnt, w0;
    logic [7:0] md [2] = '{8'h19, 8'h4E};
    logic [2:0] sc [2] = '{3'h6, 3'h3};
    int bl [2] = '{4, 8};

    sff_if i_sff_if();
    sff_dev_end i_sff_dev_end(.core_clk(core_clk), .arst_n(arst_n), .bus(i_sff_if.dev), .boot_auto(1'b0),
        .boot_wp(boot_wp), .arr_busy(arr_busy), .arr_rdata(arr_rdata), .arr_rd(arr_rd), .arr_wr(arr_wr),
        .arr_erase(arr_erase), .arr_boot(arr_boot), .arr_addr(arr_addr), .arr_wdata(arr_wdata),
        .arr_sector(arr_sector), .pdown(pdown), .x32_mode(x32_mode));
    sff_host_end i_sff_host_end(.core_clk(core_clk), .arst_n(arst_n), .bus(i_sff_if.host),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));
    sff_props i_sff_props(.core_clk(core_clk), .arst_n(arst_n), .cs_n(i_sff_if.cs_n), .cke(i_sff_if.cke),
        .ras_n(i_sff_if.ras_n), .cas_n(i_sff_if.cas_n), .mode_set_strobe_n(i_sff_if.mode_set_strobe_n),
        .we_n(i_sff_if.we_n), .dqm(i_sff_if.dqm), .addr(i_sff_if.addr), .word_sel(i_sff_if.word_sel),
        .host_oe(i_sff_if.host_oe), .dev_dq(i_sff_if.dev_dq), .dev_oe(i_sff_if.dev_oe));

    // Equal halves, so either word half reads the same value
    assign arr_rdata = {2{arr_addr[15:0]}};

    initial begin
        core_clk = 1'b0;
        forever #12.5 core_clk = ~core_clk;
    end

    always @(posedge core_clk) begin
        if (i_sff_if.dev_oe === 1'b1) oe_cnt++;
        if (arr_wr === 1'b1) begin
            wr_cnt++;
            wr_addr = arr_addr;
            wr_data = arr_wdata;
            wr_boot = arr_boot;
        end
        if (arr_erase === 1'b1) begin
            er_cnt++;
            er_sec = arr_sector;
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic wrap_up;
        $display("checks=%0d errors=%0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge core_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask

    task automatic rd(input logic [3:0] a, output logic [31:0] d);
        @(posedge core_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask

    // Start an operation and wait, bounded, for busy to drop
    task automatic op(input logic [2:0] c);
        int n;
        wr(4'h0, {29'h0, c});
        n = 0;
        rv = 32'h1;
        while (rv[0] !== 1'b0 && n < 80) begin
            rd(4'h5, rv);
            n++;
        end
        if (rv[0] !== 1'b0) begin
            chk({31'h0, rv[0]}, 32'h0);
            wrap_up();
        end
    endtask

    function automatic logic [7:0] ecol(input logic [2:0] s, input int i, input int n, input logic ilv);
        logic [2:0] m;
        m = 3'(n - 1);
        return ilv ? {5'h0, s ^ 3'(i)} : {5'h0, (s & ~m) | ((s + 3'(i)) & m)};
    endfunction

    initial begin
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 4'h0;
        reg_wdata = 32'h0;
        boot_wp = 1'b1;
        arr_busy = 1'b0;
        arst_n = 1'b0;
        repeat (12) @(posedge core_clk);
        arst_n <= 1'b1;
        rd(4'h6, rv);
        chk(rv, 32'h0);
        chk({31'h0, x32_mode}, 32'h0);
        op(3'h7);
        rd(4'h5, rv);
        chk({31'h0, rv[1]}, 32'h1);
        for (int k = 0; k < 2; k++) begin
            wr(4'h1, {24'h0, md[k]});
            op(3'h1);
            wr(4'h2, 32'h1C05);
            op(3'h2);
            wr(4'h2, {29'h0, sc[k]});
            oe_cnt = 0;
            op(3'h3);
            chk(32'(oe_cnt), 32'(bl[k]));
            for (int i = 0; i < bl[k]; i++) begin
                rd(4'(8 + i), rv);
                chk(rv, {16'h0, 8'h05, ecol(sc[k], i, bl[k], md[k][2])});
            end
        end
        wr(4'h4, 32'h2);
        oe_cnt = 0;
        op(3'h3);
        chk(32'(oe_cnt), 32'h0);
        wr(4'h4, 32'h0);
        wr(4'h3, 32'h1234ABCD);
        wr(4'h2, 32'h0005);
        op(3'h4);
        chk(32'(wr_cnt), 32'h1);
        chk({11'h0, wr_addr}, {11'h0, 13'h1C05, 8'h05});
        chk(wr_data, 32'h1234ABCD);
        wr(4'h2, 32'h1000);
        op(3'h4);
        chk(32'(er_cnt), 32'h1);
        chk({29'h0, er_sec}, 32'h7);
        w0 = wr_cnt;
        arr_busy <= 1'b1;
        wr(4'h2, 32'h0006);
        op(3'h4);
        chk(32'(wr_cnt), 32'(w0));
        arr_busy <= 1'b0;
        op(3'h6);
        rd(4'h5, rv);
        chk({31'h0, pdown}, 32'h1);
        chk({31'h0, rv[1]}, 32'h0);
        op(3'h7);
        rd(4'h5, rv);
        chk({31'h0, pdown}, 32'h0);
        // Mask on so boot reads stay off the bus during boot writes
        wr(4'h4, 32'h2);
        wr(4'h1, 32'h03);
        op(3'h1);
        wr(4'h2, 32'h0009);
        op(3'h4);
        chk(32'(wr_cnt), 32'(w0));
        boot_wp <= 1'b0;
        op(3'h4);
        chk(32'(wr_cnt), 32'(w0 + 1));
        chk({31'h0, wr_boot}, 32'h1);
        wrap_up();
    end
endmodule
